/* File: inc/vmon_pkg.sv */
// constants, register map and timing for the voltage variation monitor
package vmon_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int VW   = 16;
    localparam int DW   = 16;
    localparam int NPH  = 3;
    localparam int NIRQ = 6;
    localparam int NREG = 18;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTRL     = 8'h00;
    localparam logic [7:0] A_DIP_TH   = 8'h04;
    localparam logic [7:0] A_RISE_TH  = 8'h08;
    localparam logic [7:0] A_OUT_TH   = 8'h0c;
    localparam logic [7:0] A_RECIP    = 8'h10;
    localparam logic [7:0] A_MIN_MS   = 8'h14;
    localparam logic [7:0] A_MAX_MS   = 8'h18;
    localparam logic [7:0] A_STATUS   = 8'h1c;
    localparam logic [7:0] A_DIP_CNT  = 8'h20;
    localparam logic [7:0] A_RISE_CNT = 8'h24;
    localparam logic [7:0] A_LAST_DUR = 8'h28;
    localparam logic [7:0] A_VAL1     = 8'h2c;
    localparam logic [7:0] A_VAL2     = 8'h30;
    localparam logic [7:0] A_VAL3     = 8'h34;
    localparam logic [7:0] A_IRQ_STAT = 8'h38;
    localparam logic [7:0] A_IRQ_CLR  = 8'h3c;
    localparam logic [7:0] A_IRQ_EN   = 8'h40;
    localparam logic [7:0] A_STAMP    = 8'h44;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_EN     = 0;
    localparam int ST_DIP      = 0;
    localparam int ST_RISE     = 1;
    localparam int ST_OUT      = 2;
    localparam int IRQ_DIP_ON  = 0;
    localparam int IRQ_DIP_OFF = 1;
    localparam int IRQ_RISE_ON = 2;
    localparam int IRQ_RISE_OFF = 3;
    localparam int IRQ_OUT_ON  = 4;
    localparam int IRQ_OUT_OFF = 5;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [VW-1:0] RST_DIP_TH  = 16'h0000;
    localparam logic [VW-1:0] RST_RISE_TH = 16'hffff;
    localparam logic [VW-1:0] RST_OUT_TH  = 16'h0000;
    localparam logic [15:0]   RST_RECIP   = 16'h0000;
    localparam logic [DW-1:0] RST_MIN_MS  = 16'h000a;
    localparam logic [DW-1:0] RST_MAX_MS  = 16'h0bb8;

    // ------------------------------------------------------------
    // timing and scaling
    // ------------------------------------------------------------
    localparam int CLK_NS    = 10;
    localparam int MS_NS     = 1_000_000;
    localparam int MS_CYC    = MS_NS / CLK_NS;
    localparam int PCT_SCALE = 100;
    localparam int PCT_SHIFT = 16;

endpackage

/* File: inc/event_if.sv */
// one variation channel between the monitor and its timer
`timescale 1ns/10ps
interface event_if;
    import vmon_pkg::*;
    logic          cond;
    logic          active;
    logic          start;
    logic          stop;
    logic          counted;
    logic [DW-1:0] dur;

    modport tracker (input cond, output active, start, stop, counted, dur);
    modport user    (output cond, input active, start, stop, counted, dur);
endinterface

/* File: rtl/variation_timer.sv */
// duration timer and state of one voltage variation channel
`timescale 1ns/10ps
module variation_timer (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ce,
    input  wire logic                  enable,
    input  wire logic                  ms_tick,
    input  wire logic [vmon_pkg::DW-1:0] min_ms,
    input  wire logic [vmon_pkg::DW-1:0] max_ms,
    event_if.tracker                   ev
);
    import vmon_pkg::*;

    typedef enum logic [1:0] {IDLE, ACTIVE, EXPIRED} state_e;

    state_e        state_q, state_d;
    logic [DW-1:0] dur_q, dur_d;
    logic          start_q, stop_q, counted_q, active_q;
    logic          start_d, stop_d, counted_d;

    wire expired   = dur_q >= max_ms;
    wire qualified = (dur_q >= min_ms) && !expired;

    always_comb begin
        state_d   = state_q;
        dur_d     = dur_q;
        start_d   = 1'b0;
        stop_d    = 1'b0;
        counted_d = 1'b0;
        case (state_q)
            IDLE: begin
                dur_d = '0;
                if (enable && ev.cond) begin
                    state_d = ACTIVE;
                    start_d = 1'b1;
                end
            end
            ACTIVE: begin
                if (!ev.cond || !enable) begin
                    state_d   = IDLE;
                    stop_d    = 1'b1;
                    counted_d = qualified && enable;
                end else if (expired) begin
                    // timed out: status drops, nothing counted
                    state_d = EXPIRED;
                    stop_d  = 1'b1;
                end else if (ms_tick) begin
                    dur_d = dur_q + 1'b1;
                end
            end
            EXPIRED: begin
                // a new event needs the voltage back to normal first
                if (!ev.cond || !enable)
                    state_d = IDLE;
            end
            default: state_d = IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= IDLE;
            dur_q     <= '0;
            start_q   <= 1'b0;
            stop_q    <= 1'b0;
            counted_q <= 1'b0;
            active_q  <= 1'b0;
        end else if (ce) begin
            state_q   <= state_d;
            dur_q     <= dur_d;
            start_q   <= start_d;
            stop_q    <= stop_d;
            counted_q <= counted_d;
            active_q  <= state_d == ACTIVE;
        end
    end

    assign ev.active  = active_q;
    assign ev.start   = start_q;
    assign ev.stop    = stop_q;
    assign ev.counted = counted_q;
    assign ev.dur     = dur_q;
endmodule

/* File: rtl/voltage_sag_swell_monitor.sv */
// voltage dip, rise and interruption monitor with apb registers
//
// What this block does
// - dip status high while any voltage is below dip level and not all are below outage level
// - dip clears when all voltages recover or the longest time runs out
// - dip counter counts dips lasting between shortest and longest that recover or turn into an outage
// - each dip reports its duration and lowest value per phase
// - rise status high while any voltage exceeds the rise level
// - rise clears when all voltages drop back or longest time runs out
// - rise counter counts recovered rises lasting between shortest and longest
// - each rise reports its duration and highest value per phase unless a dip ends in the same cycle
// - interruption status high only while all voltages are below outage
// - interruption clears when any voltage recovers or time runs out
// - interruptions have no counter
// - partial outage is still a dip but its lowest value reads zero
// - last duration, values and counters held; each event overwrites duration, a dip's winning over a rise ending in the same cycle
// - time-stamped records on status changes and at each counted end
`timescale 1ns/10ps
module voltage_sag_swell_monitor #(
    parameter int MS_CYCLES = vmon_pkg::MS_CYC
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    ce,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [vmon_pkg::VW-1:0] v_ab,
    input  wire logic [vmon_pkg::VW-1:0] v_bc,
    input  wire logic [vmon_pkg::VW-1:0] v_ca,
    output logic                         dip_status,
    output logic                         rise_status,
    output logic                         outage_status,
    output logic                         irq,
    output logic                         rec_valid,
    output logic      [2:0]              rec_on,
    output logic      [2:0]              rec_off,
    output logic                         rec_counted,
    output logic      [vmon_pkg::DW-1:0] rec_count,
    output logic      [vmon_pkg::DW-1:0] rec_dur,
    output logic      [15:0]             rec_val1,
    output logic      [15:0]             rec_val2,
    output logic      [15:0]             rec_val3,
    output logic      [31:0]             rec_stamp
);
    import vmon_pkg::*;

    // ------------------------------------------------------------
    // settings and held results
    // ------------------------------------------------------------
    logic            en_q;
    logic [VW-1:0]   dip_th_q, rise_th_q, out_th_q;
    logic [15:0]     recip_q;
    logic [DW-1:0]   min_ms_q, max_ms_q;
    logic [DW-1:0]   dip_cnt_q, rise_cnt_q, last_dur_q;
    logic [15:0]     last_val_q [NPH];
    logic [NIRQ-1:0] irq_stat_q, irq_en_q;
    logic [31:0]     pre_q, stamp_q;
    logic            tick_q;
    logic            pready_q, pslverr_q;
    logic [31:0]     prdata_q;

    // ------------------------------------------------------------
    // threshold compare
    // ------------------------------------------------------------
    wire [VW-1:0] v [NPH];
    assign v[0] = v_ab;
    assign v[1] = v_bc;
    assign v[2] = v_ca;

    wire [NPH-1:0] below_dip, below_out, above_rise;
    genvar g;
    generate
        for (g = 0; g < NPH; g++) begin : g_cmp
            assign below_dip[g]  = v[g] < dip_th_q;
            assign below_out[g]  = v[g] < out_th_q;
            assign above_rise[g] = v[g] > rise_th_q;
        end
    endgenerate

    wire all_out  = &below_out;
    wire any_dip  = |below_dip && !all_out;
    wire any_rise = |above_rise;

    // ------------------------------------------------------------
    // millisecond timebase
    // ------------------------------------------------------------
    wire pre_end = pre_q == 32'(MS_CYCLES - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q   <= '0;
            stamp_q <= '0;
            tick_q  <= 1'b0;
        end else if (ce) begin
            pre_q   <= pre_end ? '0 : pre_q + 1'b1;
            stamp_q <= stamp_q + {31'h0000_0000, pre_end};
            tick_q  <= pre_end;
        end
    end

    // ------------------------------------------------------------
    // the three variation timers
    // ------------------------------------------------------------
    event_if dip_ev ();
    event_if rise_ev ();
    event_if out_ev ();

    assign dip_ev.cond  = any_dip;
    assign rise_ev.cond = any_rise;
    assign out_ev.cond  = all_out;

    variation_timer u_dip (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .enable  (en_q),
        .ms_tick (tick_q),
        .min_ms  (min_ms_q),
        .max_ms  (max_ms_q),
        .ev      (dip_ev.tracker)
    );

    variation_timer u_rise (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .enable  (en_q),
        .ms_tick (tick_q),
        .min_ms  (min_ms_q),
        .max_ms  (max_ms_q),
        .ev      (rise_ev.tracker)
    );

    variation_timer u_out (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .enable  (en_q),
        .ms_tick (tick_q),
        .min_ms  (min_ms_q),
        .max_ms  (max_ms_q),
        .ev      (out_ev.tracker)
    );

    // ------------------------------------------------------------
    // per-phase extremes
    // ------------------------------------------------------------
    // percent uses a reciprocal of nominal so no divider is needed
    function automatic logic [15:0] pct(input logic [15:0] x,
                                        input logic [15:0] r);
        logic [38:0] p;
        p = 39'(x) * 39'(PCT_SCALE) * 39'(r);
        pct = (|p[38:32]) ? 16'hffff : p[PCT_SHIFT+15:PCT_SHIFT];
    endfunction

    logic [VW-1:0] vmin_q [NPH];
    logic [VW-1:0] vmax_q [NPH];
    logic          part_out_q;
    wire  [15:0]   dip_pct  [NPH];
    wire  [15:0]   rise_pct [NPH];

    generate
        for (g = 0; g < NPH; g++) begin : g_ext
            // while idle the trackers follow the input, so the
            // first active sample is the detection sample
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    vmin_q[g] <= '0;
                    vmax_q[g] <= '0;
                end else if (ce) begin
                    if (!dip_ev.active || v[g] < vmin_q[g])
                        vmin_q[g] <= v[g];
                    if (!rise_ev.active || v[g] > vmax_q[g])
                        vmax_q[g] <= v[g];
                end
            end
            assign dip_pct[g]  = part_out_q ? 16'h0000
                               : pct(vmin_q[g], recip_q);
            assign rise_pct[g] = pct(vmax_q[g], recip_q);
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            part_out_q <= 1'b0;
        else if (ce)
            part_out_q <= (dip_ev.active && part_out_q) | (|below_out);
    end

    // ------------------------------------------------------------
    // counters and held results
    // ------------------------------------------------------------
    wire [2:0] on_w  = {out_ev.start, rise_ev.start, dip_ev.start};
    wire [2:0] off_w = {out_ev.stop, rise_ev.stop, dip_ev.stop};
    wire [DW-1:0] dip_cnt_d  = dip_cnt_q + {15'h0000, dip_ev.counted};
    wire [DW-1:0] rise_cnt_d = rise_cnt_q + {15'h0000, rise_ev.counted};
    wire [DW-1:0] dur_d = dip_ev.stop  ? dip_ev.dur
                        : rise_ev.stop ? rise_ev.dur
                        : out_ev.stop  ? out_ev.dur : last_dur_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dip_cnt_q  <= '0;
            rise_cnt_q <= '0;
            last_dur_q <= '0;
        end else if (ce) begin
            dip_cnt_q  <= dip_cnt_d;
            rise_cnt_q <= rise_cnt_d;
            last_dur_q <= dur_d;
        end
    end

    generate
        for (g = 0; g < NPH; g++) begin : g_val
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    last_val_q[g] <= '0;
                else if (ce && dip_ev.stop)
                    last_val_q[g] <= dip_pct[g];
                else if (ce && rise_ev.stop)
                    last_val_q[g] <= rise_pct[g];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // event records
    // ------------------------------------------------------------
    logic          rv_q, rc_q;
    logic [2:0]    ron_q, roff_q;
    logic [DW-1:0] rcnt_q, rdur_q;
    logic [15:0]   rval_q [NPH];
    logic [31:0]   rst_q;

    wire cnt_any = dip_ev.counted | rise_ev.counted;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rv_q   <= 1'b0;
            rc_q   <= 1'b0;
            ron_q  <= '0;
            roff_q <= '0;
            rcnt_q <= '0;
            rdur_q <= '0;
            rst_q  <= '0;
        end else if (ce) begin
            rv_q   <= |{on_w, off_w};
            ron_q  <= on_w;
            roff_q <= off_w;
            rc_q   <= cnt_any;
            rcnt_q <= dip_ev.counted ? dip_cnt_d : rise_cnt_d;
            rdur_q <= dur_d;
            rst_q  <= stamp_q;
        end
    end

    generate
        for (g = 0; g < NPH; g++) begin : g_rval
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    rval_q[g] <= '0;
                else if (ce)
                    rval_q[g] <= dip_ev.stop ? dip_pct[g] : rise_pct[g];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    wire        setup  = psel && !penable && !pready_q;
    wire        wr     = psel && penable && pwrite && pready_q;
    wire [4:0]  idx    = paddr[6:2];
    wire        hit    = paddr[1:0] == 2'b00 && !paddr[7]
                         && idx < 5'(NREG);
    wire        wr_ok  = wr && !pslverr_q;
    wire        wr_clr = wr_ok && paddr == A_IRQ_CLR;

    wire [31:0] rmap [NREG];
    assign rmap[0]  = {31'h0000_0000, en_q};
    assign rmap[1]  = {16'h0000, dip_th_q};
    assign rmap[2]  = {16'h0000, rise_th_q};
    assign rmap[3]  = {16'h0000, out_th_q};
    assign rmap[4]  = {16'h0000, recip_q};
    assign rmap[5]  = {16'h0000, min_ms_q};
    assign rmap[6]  = {16'h0000, max_ms_q};
    assign rmap[7]  = {29'h0000_0000, outage_status, rise_status,
                       dip_status};
    assign rmap[8]  = {16'h0000, dip_cnt_q};
    assign rmap[9]  = {16'h0000, rise_cnt_q};
    assign rmap[10] = {16'h0000, last_dur_q};
    assign rmap[11] = {16'h0000, last_val_q[0]};
    assign rmap[12] = {16'h0000, last_val_q[1]};
    assign rmap[13] = {16'h0000, last_val_q[2]};
    assign rmap[14] = {26'h0000_000, irq_stat_q};
    assign rmap[15] = 32'h0000_0000;
    assign rmap[16] = {26'h0000_000, irq_en_q};
    assign rmap[17] = stamp_q;

    wire [31:0] rdata = hit ? rmap[idx] : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else if (ce) begin
            pready_q  <= setup;
            pslverr_q <= setup && !hit;
            if (setup)
                prdata_q <= rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q      <= 1'b0;
            dip_th_q  <= RST_DIP_TH;
            rise_th_q <= RST_RISE_TH;
            out_th_q  <= RST_OUT_TH;
            recip_q   <= RST_RECIP;
            min_ms_q  <= RST_MIN_MS;
            max_ms_q  <= RST_MAX_MS;
            irq_en_q  <= '0;
        end else if (ce && wr_ok) begin
            case (paddr)
                A_CTRL:    en_q      <= pwdata[CTRL_EN];
                A_DIP_TH:  dip_th_q  <= pwdata[VW-1:0];
                A_RISE_TH: rise_th_q <= pwdata[VW-1:0];
                A_OUT_TH:  out_th_q  <= pwdata[VW-1:0];
                A_RECIP:   recip_q   <= pwdata[15:0];
                A_MIN_MS:  min_ms_q  <= pwdata[DW-1:0];
                A_MAX_MS:  max_ms_q  <= pwdata[DW-1:0];
                A_IRQ_EN:  irq_en_q  <= pwdata[NIRQ-1:0];
                default:   en_q      <= en_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------
    // a new event in the clearing cycle survives the clear
    wire [NIRQ-1:0] irq_set = {out_ev.stop, out_ev.start,
                               rise_ev.stop, rise_ev.start,
                               dip_ev.stop, dip_ev.start};
    wire [NIRQ-1:0] irq_clr = wr_clr ? pwdata[NIRQ-1:0] : '0;

    logic irq_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
            irq_q      <= 1'b0;
        end else if (ce) begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
            irq_q      <= |(((irq_stat_q & ~irq_clr) | irq_set)
                            & irq_en_q);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata        = prdata_q;
    assign pready        = pready_q;
    assign pslverr       = pslverr_q;
    assign dip_status    = dip_ev.active;
    assign rise_status   = rise_ev.active;
    assign outage_status = out_ev.active;
    assign irq           = irq_q;
    assign rec_valid     = rv_q;
    assign rec_on        = ron_q;
    assign rec_off       = roff_q;
    assign rec_counted   = rc_q;
    assign rec_count     = rcnt_q;
    assign rec_dur       = rdur_q;
    assign rec_val1      = rval_q[0];
    assign rec_val2      = rval_q[1];
    assign rec_val3      = rval_q[2];
    assign rec_stamp     = rst_q;
endmodule

/* File: test/vmon_chk.sv */
// port assertions for the voltage variation monitor
`timescale 1ns/10ps
module vmon_chk (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       ce,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       dip_status,
    input wire logic       rise_status,
    input wire logic       outage_status,
    input wire logic       rec_valid,
    input wire logic [2:0] rec_on,
    input wire logic [2:0] rec_off,
    input wire logic       rec_counted
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------------------------
    // status and record checks
    // ----------------------------------------------------------
    a_dip_out_excl: assert property (!(dip_status &&
        outage_status)) else $error("dip and outage high together");
    a_dip_on_rec: assert property ($rose(dip_status) |=>
        rec_valid && rec_on[0]) else $error("dip start without record");
    a_dip_off_rec: assert property ($fell(dip_status) |=>
        rec_valid && rec_off[0]) else $error("dip end without record");
    a_rise_on_rec: assert property ($rose(rise_status) |=>
        rec_valid && rec_on[1]) else $error("rise start without record");
    a_rise_off_rec: assert property ($fell(rise_status) |=>
        rec_off[1]) else $error("rise end without record");
    a_out_on_rec: assert property ($rose(outage_status) |=>
        rec_on[2]) else $error("outage start without record");
    a_counted_end: assert property (rec_counted |->
        rec_valid && |rec_off[1:0]) else $error("stray count record");
    // ----------------------------------------------------------
    // bus checks
    // ----------------------------------------------------------
    a_apb_answer: assert property (psel && !penable && ce |=> pready)
        else $error("no answer after setup");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule
bind voltage_sag_swell_monitor vmon_chk i_vmon_chk (.pclk, .presetn, .ce,
    .psel, .penable, .pready, .pslverr, .dip_status, .rise_status,
    .outage_status, .rec_valid, .rec_on, .rec_off, .rec_counted);

/* File: test/rms_source.sv */
// measurement stage model: rms values follow the set levels
`timescale 1ns/10ps
module rms_source (
    input  wire logic        pclk,
    input  wire logic [15:0] lvl_ab,
    input  wire logic [15:0] lvl_bc,
    input  wire logic [15:0] lvl_ca,
    output logic      [15:0] v_ab,
    output logic      [15:0] v_bc,
    output logic      [15:0] v_ca
);
    // one update per clock, like a filter refreshing its output
    always_ff @(posedge pclk) begin
        v_ab <= lvl_ab;
        v_bc <= lvl_bc;
        v_ca <= lvl_ca;
    end
endmodule

/* File: test/voltage_sag_swell_monitor_tb.sv */
// self-checking bench for the voltage variation monitor
`timescale 1ns/10ps
module voltage_sag_swell_monitor_tb;
    import vmon_pkg::*;
    localparam logic [15:0] NOM = 16'h2000;
    localparam logic [15:0] LOW = 16'h1800;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        irq, rec_valid, rec_counted, dip_status, rise_status;
    logic        outage_status;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, rec_stamp;
    logic [2:0]  rec_on, rec_off;
    logic [15:0] rec_count, rec_dur, rec_val1, rec_val2, rec_val3;
    logic [15:0] lvl_ab, lvl_bc, lvl_ca, v_ab, v_bc, v_ca, r_cnt, r_val;
    int          miscompares, check_count;
    voltage_sag_swell_monitor #(.MS_CYCLES(10)) i_voltage_sag_swell_monitor (
        .pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .v_ab, .v_bc, .v_ca,
        .dip_status, .rise_status, .outage_status, .irq, .rec_valid,
        .rec_on, .rec_off, .rec_counted, .rec_count, .rec_dur, .rec_val1,
        .rec_val2, .rec_val3, .rec_stamp);
    rms_source i_rms_source (.pclk, .lvl_ab, .lvl_bc, .lvl_ca, .v_ab,
        .v_bc, .v_ca);
    always #5 pclk = ~pclk;
    always @(posedge pclk)
        if (rec_counted) {r_cnt, r_val} <= {rec_count, rec_val1};
    // ----------------------------------------------------------
    // tasks
    // ----------------------------------------------------------
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(string nm, logic [7:0] a, logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(nm, rd, exp);
    endtask
    task automatic volts(logic [15:0] a, logic [15:0] b, logic [15:0] c,
                         int cyc);
        lvl_ab <= a;
        lvl_bc <= b;
        lvl_ca <= c;
        repeat (cyc) @(posedge pclk);
    endtask
    // percent with recip 8, nominal 0x2000
    function automatic logic [31:0] pct(logic [15:0] v);
        return (32'(v) * 800) >> 16;
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------------------------
    // sequence
    // ----------------------------------------------------------
    initial begin
        #100_000;
        miscompares++;
        give_verdict();
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {lvl_ab, lvl_bc, lvl_ca} = {NOM, NOM, NOM};
        {miscompares, check_count} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdc("rise_th reset", A_RISE_TH, 32'h0000_ffff);
        rdc("max_ms reset", A_MAX_MS, 32'h0000_0bb8);
        xfer(1'b0, 8'h48, 32'h0000_0000);
        chk("unmapped err", err, 1'b1);
        xfer(1'b1, A_DIP_TH, 32'h0000_1c00);
        xfer(1'b1, A_RISE_TH, 32'h0000_3000);
        xfer(1'b1, A_OUT_TH, 32'h0000_0800);
        xfer(1'b1, A_RECIP, 32'h0000_0008);
        xfer(1'b1, A_MIN_MS, 32'h0000_0002);
        xfer(1'b1, A_MAX_MS, 32'h0000_0014);
        xfer(1'b1, A_IRQ_EN, 32'h0000_0001);
        xfer(1'b1, A_CTRL, 32'h0000_0001);
        volts(LOW, NOM, NOM, 60);
        chk("dip on", dip_status, 1'b1);
        chk("irq on", irq, 1'b1);
        volts(NOM, NOM, NOM, 5);
        chk("dip off", dip_status, 1'b0);
        rdc("dip count", A_DIP_CNT, 32'h0000_0001);
        rdc("val1", A_VAL1, pct(LOW));
        rdc("val2", A_VAL2, pct(NOM));
        chk("rec count", r_cnt, 16'h0001);
        chk("rec val1", r_val, pct(LOW));
        xfer(1'b0, A_LAST_DUR, 32'h0000_0000);
        chk("last dur", rd inside {[5:7]}, 1'b1);
        xfer(1'b1, A_IRQ_CLR, 32'h0000_003f);
        rdc("irq cleared", A_IRQ_STAT, 32'h0000_0000);
        chk("irq off", irq, 1'b0);
        volts(NOM, 16'h3800, NOM, 60);
        chk("rise on", rise_status, 1'b1);
        chk("irq masked", irq, 1'b0);
        volts(NOM, NOM, NOM, 5);
        chk("rise off", rise_status, 1'b0);
        rdc("rise count", A_RISE_CNT, 32'h0000_0001);
        rdc("rise max", A_VAL2, pct(16'h3800));
        volts(LOW, NOM, NOM, 5);
        volts(NOM, NOM, NOM, 5);
        rdc("short dip", A_DIP_CNT, 32'h0000_0001);
        volts(16'h0400, NOM, NOM, 60);
        chk("partial dip", dip_status, 1'b1);
        volts(NOM, NOM, NOM, 5);
        rdc("partial min", A_VAL1, 32'h0000_0000);
        volts(16'h0400, 16'h0400, 16'h0400, 60);
        chk("outage on", outage_status, 1'b1);
        chk("dip held off", dip_status, 1'b0);
        volts(NOM, NOM, NOM, 5);
        chk("outage off", outage_status, 1'b0);
        volts(LOW, NOM, NOM, 250);
        chk("dip timeout", dip_status, 1'b0);
        volts(NOM, NOM, NOM, 5);
        rdc("no extra count", A_DIP_CNT, 32'h0000_0002);
        give_verdict();
    end
endmodule
